// ---- css_pkg.sv ----
package css_pkg;
    // clock source select encoding
    localparam logic [1:0] SRC_PRIMARY   = 2'h0;
    localparam logic [1:0] SRC_SECONDARY = 2'h1;
    localparam logic [1:0] SRC_INTERNAL  = 2'h2;
    localparam logic [1:0] SRC_INTERNAL2 = 2'h3;

    // reset values
    localparam logic [1:0] CLOCK_SOURCE_SELECT_RST  = 2'h0;
    localparam logic [2:0] INTERNAL_FREQ_SELECT_RST = 3'h4;
    localparam logic       LOW_FREQ_SOURCE_RST      = 1'b0;
    localparam logic       IDLE_ON_SLEEP_RST        = 1'b0;
    localparam logic [3:0] PRIMARY_OSC_CONFIG_RST   = 4'h0;

    // internal frequency select codes
    localparam logic [2:0] IFS_31K   = 3'h0;
    localparam logic [2:0] IFS_8M    = 3'h7;
    localparam int         IFS_WIDTH = 3;
    localparam int         DIV_WIDTH = 8;

    // secondary timer control bit positions
    localparam int SEC_OSC_ENABLE_BIT  = 3;
    localparam int SEC_CLK_RUNNING_BIT = 6;
    // tuning register bit position
    localparam int LOW_FREQ_SOURCE_BIT = 7;

    // switch pause, in source ticks
    localparam logic [2:0] OLD_SRC_PAUSE_TICKS = 3'h2;
    localparam logic [2:0] NEW_SRC_PAUSE_TICKS = 3'h3;

    // timing
    localparam int CLK_MHZ            = 20;
    localparam int STARTUP_SRC_TICKS  = 1024;
    localparam int PLL_STARTUP_US     = 2000;
    localparam int PLL_STARTUP_CYCLES = PLL_STARTUP_US * CLK_MHZ;
    localparam int INT_SETTLE_US      = 1;
    localparam int INT_SETTLE_CYCLES  = INT_SETTLE_US * CLK_MHZ;
    localparam int TIMER_WIDTH        = 16;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_OLD_WAIT,
        SW_NEW_WAIT
    } css_sw_state_t;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_SLEEP
    } css_pm_state_t;
endpackage

// ---- css_postscaler.sv ----
`timescale 1ns/1ps
module css_postscaler (
    input  wire logic                          i_clk,
    input  wire logic                          i_reset_n,
    input  wire logic                          i_fast_tick,
    input  wire logic                          i_slow_tick,
    input  wire logic [css_pkg::IFS_WIDTH-1:0] i_freq_sel,
    input  wire logic                          i_low_freq_source_select,
    output logic                               o_tick
);
    logic [css_pkg::DIV_WIDTH-1:0] div_ff;
    logic                          tick_ff;
    logic [css_pkg::DIV_WIDTH-1:0] mask;

    // code n divides the fast source by 2^(7-n); code 0 with the fast source divides by 256
    function automatic logic [css_pkg::DIV_WIDTH-1:0] div_mask(input logic [2:0] sel);
        logic [css_pkg::DIV_WIDTH-1:0] m;
        m = 8'hFF;
        if (sel != css_pkg::IFS_31K) begin
            m = 8'(8'hFF >> (4'(sel) + 4'h1));
        end
        return m;
    endfunction

    assign mask = div_mask(i_freq_sel);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_ff <= '0;
        end else if (i_fast_tick) begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // mask applies combinationally so a new select takes effect on the next tick
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_ff <= 1'b0;
        end else if (i_freq_sel == css_pkg::IFS_31K && !i_low_freq_source_select) begin
            tick_ff <= i_slow_tick;
        end else begin
            tick_ff <= i_fast_tick && ((div_ff & mask) == mask);
        end
    end

    assign o_tick = tick_ff;
endmodule

// ---- css_clock_switch.sv ----
`timescale 1ns/1ps
module css_clock_switch #(
    parameter int PLL_STARTUP_CYCLES = css_pkg::PLL_STARTUP_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_primary_tick,
    input  wire logic       i_secondary_tick,
    input  wire logic       i_fast_internal_tick,
    input  wire logic       i_slow_internal_tick,
    input  wire logic [3:0] i_primary_osc_config,
    input  wire logic       i_pll_enable,
    input  wire logic       i_ctrl_write,
    input  wire logic [1:0] i_clock_source_select,
    input  wire logic [2:0] i_internal_freq_select,
    input  wire logic       i_idle_on_sleep_select,
    input  wire logic       i_tune_write,
    input  wire logic       i_low_freq_source_select,
    input  wire logic       i_secondary_osc_enable,
    input  wire logic       i_sleep,
    input  wire logic       i_wake,
    output logic            o_sys_clk_en,
    output logic            o_wdt_clk_en,
    output logic [1:0]      o_active_source,
    output logic [1:0]      o_clock_source_select,
    output logic [2:0]      o_internal_freq_select,
    output logic            o_low_freq_source_select,
    output logic            o_idle_on_sleep_select,
    output logic [3:0]      o_primary_osc_config,
    output logic            o_primary_startup_done,
    output logic            o_internal_freq_stable,
    output logic            o_secondary_clock_running,
    output logic            o_fast_internal_osc_on,
    output logic            o_secondary_osc_run,
    output logic            o_switching,
    output logic            o_idle_mode,
    output logic            o_sleep_mode
);
    logic [1:0]                  sel_ff;
    logic [2:0]                  ifs_ff;
    logic                        lfss_ff;
    logic                        idle_sel_ff;
    logic [3:0]                  cfg_ff;
    logic                        cfg_taken_ff;
    logic [1:0]                  active_ff;
    logic [1:0]                  target_ff;
    css_pkg::css_sw_state_t      sw_ff;
    logic [2:0]                  pause_ff;
    css_pkg::css_pm_state_t      pm_ff;
    logic [10:0]                 ost_ff;
    logic                        ost_done_ff;
    logic [css_pkg::TIMER_WIDTH-1:0] pll_ff;
    logic                        pll_done_ff;
    logic [css_pkg::TIMER_WIDTH-1:0] settle_ff;
    logic                        settled_ff;
    logic                        sys_en_ff;
    logic                        wdt_en_ff;
    logic                        primary_startup_done_ff;
    logic                        internal_freq_stable_ff;
    logic                        secondary_clock_running_ff;
    logic                        fast_on_ff;
    logic                        sec_run_ff;
    logic                        internal_tick;
    logic                        old_tick;
    logic                        new_tick;
    logic                        sw_start;
    logic                        switching_ff;
    logic                        idle_ff, sleep_ff;
    logic                        slow_internal_osc_only;

    // sources: 00 primary, 01 secondary, 1x internal block
    function automatic logic is_internal(input logic [1:0] src);
        return src[1];
    endfunction

    function automatic logic src_tick(input logic [1:0] src, input logic pri, input logic sec,
                                      input logic intl);
        logic t;
        t = intl;
        if (src == css_pkg::SRC_PRIMARY) begin
            t = pri;
        end else if (src == css_pkg::SRC_SECONDARY) begin
            t = sec;
        end
        return t;
    endfunction

    css_postscaler u_postscaler (
        .i_clk                    (i_clk),
        .i_reset_n                (i_reset_n),
        .i_fast_tick              (i_fast_internal_tick),
        .i_slow_tick              (i_slow_internal_tick),
        .i_freq_sel               (ifs_ff),
        .i_low_freq_source_select (lfss_ff),
        .o_tick                   (internal_tick)
    );

    assign old_tick    = src_tick(active_ff, i_primary_tick, i_secondary_tick, internal_tick);
    assign new_tick    = src_tick(target_ff, i_primary_tick, i_secondary_tick, internal_tick);
    assign sw_start    = sel_ff != active_ff && !(is_internal(sel_ff) && is_internal(active_ff));
    assign slow_internal_osc_only  = (ifs_ff == css_pkg::IFS_31K) && !lfss_ff;

    // source select register; reset covers every reset source
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_ff <= css_pkg::CLOCK_SOURCE_SELECT_RST;
        end else if (i_ctrl_write) begin
            if (i_clock_source_select != css_pkg::SRC_SECONDARY || i_secondary_osc_enable) begin
                sel_ff <= i_clock_source_select;
            end
        end
    end

    // frequency select; reset gives the 1 MHz code
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ifs_ff <= css_pkg::INTERNAL_FREQ_SELECT_RST;
        end else if (i_ctrl_write) begin
            ifs_ff <= i_internal_freq_select;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idle_sel_ff <= css_pkg::IDLE_ON_SLEEP_RST;
        end else if (i_ctrl_write) begin
            idle_sel_ff <= i_idle_on_sleep_select;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lfss_ff <= css_pkg::LOW_FREQ_SOURCE_RST;
        end else if (i_tune_write) begin
            lfss_ff <= i_low_freq_source_select;
        end
    end

    // configuration is caught once after reset release and then held
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_ff       <= css_pkg::PRIMARY_OSC_CONFIG_RST;
            cfg_taken_ff <= 1'b0;
        end else if (!cfg_taken_ff) begin
            cfg_ff       <= i_primary_osc_config;
            cfg_taken_ff <= 1'b1;
        end
    end

    // switch sequencer: hold the clock for 2 old then 3 new ticks
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sw_ff     <= css_pkg::SW_RUN;
            pause_ff  <= '0;
            switching_ff <= 1'b0;
            active_ff <= css_pkg::CLOCK_SOURCE_SELECT_RST;
            target_ff <= css_pkg::CLOCK_SOURCE_SELECT_RST;
        end else begin
            unique case (sw_ff)
                css_pkg::SW_RUN: begin
                    if (sw_start) begin
                        sw_ff     <= css_pkg::SW_OLD_WAIT;
                        switching_ff <= 1'b1;
                        target_ff <= sel_ff;
                        pause_ff  <= '0;
                    end else begin
                        active_ff <= sel_ff;
                        target_ff <= sel_ff;
                    end
                end
                css_pkg::SW_OLD_WAIT: begin
                    if (old_tick) begin
                        if (pause_ff == css_pkg::OLD_SRC_PAUSE_TICKS - 3'h1) begin
                            sw_ff    <= css_pkg::SW_NEW_WAIT;
                            pause_ff <= '0;
                        end else begin
                            pause_ff <= pause_ff + 3'h1;
                        end
                    end
                end
                css_pkg::SW_NEW_WAIT: begin
                    if (new_tick) begin
                        if (pause_ff == css_pkg::NEW_SRC_PAUSE_TICKS - 3'h1) begin
                            sw_ff     <= css_pkg::SW_RUN;
                            active_ff <= target_ff;
                            switching_ff <= 1'b0;
                            pause_ff  <= '0;
                        end else begin
                            pause_ff <= pause_ff + 3'h1;
                        end
                    end
                end
                default: begin
                    sw_ff <= css_pkg::SW_RUN;
                end
            endcase
        end
    end

    // power-managed state on sleep
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pm_ff <= css_pkg::PM_RUN;
            {idle_ff, sleep_ff} <= 2'h0;
        end else begin
            unique case (pm_ff)
                css_pkg::PM_RUN: begin
                    if (i_sleep) begin
                        pm_ff <= idle_sel_ff ? css_pkg::PM_IDLE : css_pkg::PM_SLEEP;
                        {idle_ff, sleep_ff} <= {idle_sel_ff, !idle_sel_ff};
                    end
                end
                css_pkg::PM_IDLE,
                css_pkg::PM_SLEEP: begin
                    if (i_wake) begin
                        pm_ff <= css_pkg::PM_RUN;
                        {idle_ff, sleep_ff} <= 2'h0;
                    end
                end
                default: begin
                    pm_ff <= css_pkg::PM_RUN;
                end
            endcase
        end
    end

    // start-up timer counts primary ticks outside full sleep, whatever source is selected
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ost_ff      <= '0;
            ost_done_ff <= 1'b0;
        end else if (pm_ff == css_pkg::PM_SLEEP) begin
            ost_ff      <= '0;
            ost_done_ff <= 1'b0;
        end else if (!ost_done_ff && i_primary_tick) begin
            if (ost_ff == 11'(css_pkg::STARTUP_SRC_TICKS - 1)) begin
                ost_done_ff <= 1'b1;
            end else begin
                ost_ff <= ost_ff + 11'h001;
            end
        end
    end

    // pll start-up timer in system clock cycles
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pll_ff      <= '0;
            pll_done_ff <= 1'b0;
        end else if (!i_pll_enable || pm_ff == css_pkg::PM_SLEEP) begin
            pll_ff      <= '0;
            pll_done_ff <= 1'b0;
        end else if (!pll_done_ff) begin
            if (pll_ff == css_pkg::TIMER_WIDTH'(PLL_STARTUP_CYCLES - 1)) begin
                pll_done_ff <= 1'b1;
            end else begin
                pll_ff <= pll_ff + 16'h0001;
            end
        end
    end

    // fast oscillator settling; restarts whenever it is powered down
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            settle_ff  <= '0;
            settled_ff <= 1'b0;
        end else if (!fast_on_ff) begin
            settle_ff  <= '0;
            settled_ff <= 1'b0;
        end else if (!settled_ff) begin
            if (settle_ff == css_pkg::TIMER_WIDTH'(css_pkg::INT_SETTLE_CYCLES - 1)) begin
                settled_ff <= 1'b1;
            end else begin
                settle_ff <= settle_ff + 16'h0001;
            end
        end
    end

    // fast osc off only when nothing needs it: slow_internal_osc at 31 kHz or full sleep
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fast_on_ff <= 1'b1;
        end else begin
            fast_on_ff <= !(slow_internal_osc_only && is_internal(active_ff) && is_internal(sel_ff))
                          && pm_ff != css_pkg::PM_SLEEP;
        end
    end

    // secondary oscillator follows its enable, not the power mode
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sec_run_ff <= 1'b0;
        end else begin
            sec_run_ff <= i_secondary_osc_enable;
        end
    end

    // gated system clock enable; stops during a switch and in idle or full sleep
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sys_en_ff <= 1'b0;
        end else begin
            sys_en_ff <= old_tick && sw_ff == css_pkg::SW_RUN
                         && pm_ff == css_pkg::PM_RUN && !sw_start;
        end
    end

    // watchdog tick never depends on source or frequency choice
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wdt_en_ff <= 1'b0;
        end else begin
            wdt_en_ff <= i_slow_internal_tick;
        end
    end

    // status flags are qualified by the active source so at most one is set
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            primary_startup_done_ff  <= 1'b0;
            internal_freq_stable_ff  <= 1'b0;
            secondary_clock_running_ff <= 1'b0;
        end else begin
            primary_startup_done_ff  <= active_ff == css_pkg::SRC_PRIMARY && sw_ff == css_pkg::SW_RUN
                        && ost_done_ff && (pll_done_ff || !i_pll_enable);
            internal_freq_stable_ff  <= is_internal(active_ff) && sw_ff == css_pkg::SW_RUN
                        && settled_ff && !slow_internal_osc_only;
            secondary_clock_running_ff <= active_ff == css_pkg::SRC_SECONDARY
                        && sw_ff == css_pkg::SW_RUN;
        end
    end

    assign o_sys_clk_en              = sys_en_ff;
    assign o_wdt_clk_en              = wdt_en_ff;
    assign o_active_source           = active_ff;
    assign o_clock_source_select     = sel_ff;
    assign o_internal_freq_select    = ifs_ff;
    assign o_low_freq_source_select  = lfss_ff;
    assign o_idle_on_sleep_select    = idle_sel_ff;
    assign o_primary_osc_config      = cfg_ff;
    assign o_primary_startup_done    = primary_startup_done_ff;
    assign o_internal_freq_stable    = internal_freq_stable_ff;
    assign o_secondary_clock_running = secondary_clock_running_ff;
    assign o_fast_internal_osc_on    = fast_on_ff;
    assign o_secondary_osc_run       = sec_run_ff;
    assign o_switching               = switching_ff;
    assign o_idle_mode               = idle_ff;
    assign o_sleep_mode              = sleep_ff;
endmodule

// ---- css_osc_model.sv ----
`timescale 1ns/1ps
module css_osc_model #(
    parameter int SEC_PERIOD  = 7,
    parameter int SLOW_PERIOD = 20
) (
    input  wire logic i_clk,
    input  wire logic i_sec_enable,
    output logic      o_primary_tick,
    output logic      o_secondary_tick,
    output logic      o_fast_tick,
    output logic      o_slow_tick
);
    int sec_cnt = 0;
    int slow_cnt = 0;
    int fast_cnt = 0;
    initial begin
        o_primary_tick = 1'b0;
        o_secondary_tick = 1'b0;
        o_fast_tick = 1'b0;
        o_slow_tick = 1'b0;
    end
    // primary crystal at half the system rate
    always @(posedge i_clk) begin
        o_primary_tick <= !o_primary_tick;
    end
    // 8 MHz against 20 MHz: two ticks in every five clocks
    always @(posedge i_clk) begin
        fast_cnt <= (fast_cnt + 1) % 5;
        o_fast_tick <= (fast_cnt == 0) || (fast_cnt == 2);
    end
    // the slow osc never stops; the secondary is dead while not enabled
    always @(posedge i_clk) begin
        slow_cnt <= (slow_cnt + 1) % SLOW_PERIOD;
        sec_cnt <= (sec_cnt + 1) % SEC_PERIOD;
        o_slow_tick <= slow_cnt == 0;
        o_secondary_tick <= i_sec_enable && (sec_cnt == 0);
    end
endmodule

// ---- css_clock_switch_properties.sv ----
`timescale 1ns/1ps
module css_chk (
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic       i_slow_internal_tick,
    input wire logic       i_ctrl_write,
    input wire logic [1:0] i_clock_source_select,
    input wire logic [2:0] i_internal_freq_select,
    input wire logic       i_idle_on_sleep_select,
    input wire logic       i_secondary_osc_enable,
    input wire logic       i_sleep,
    input wire logic       i_wake,
    input wire logic       o_sys_clk_en,
    input wire logic       o_wdt_clk_en,
    input wire logic [1:0] o_active_source,
    input wire logic [1:0] o_clock_source_select,
    input wire logic [2:0] o_internal_freq_select,
    input wire logic       o_low_freq_source_select,
    input wire logic       o_idle_on_sleep_select,
    input wire logic       o_primary_startup_done,
    input wire logic       o_internal_freq_stable,
    input wire logic       o_secondary_clock_running,
    input wire logic       o_secondary_osc_run,
    input wire logic       o_switching,
    input wire logic       o_idle_mode,
    input wire logic       o_sleep_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_wdt_follows_slow: assert property (i_slow_internal_tick |=> o_wdt_clk_en)
        else $error("watchdog tick lost");
    a_refused_secondary: assert property (i_ctrl_write && i_clock_source_select == 2'h1
        && !i_secondary_osc_enable |=> $stable(o_clock_source_select)) else $error("refused select loaded");
    a_select_loads: assert property (i_ctrl_write && (i_clock_source_select != 2'h1 || i_secondary_osc_enable)
        |=> o_clock_source_select == $past(i_clock_source_select)) else $error("select not loaded");
    a_freq_loads: assert property (i_ctrl_write |=> o_internal_freq_select == $past(i_internal_freq_select)
        && o_idle_on_sleep_select == $past(i_idle_on_sleep_select)) else $error("freq or idle not loaded");
    a_flags_onehot: assert property ($onehot0({o_primary_startup_done, o_internal_freq_stable,
        o_secondary_clock_running})) else $error("more than one source flag");
    a_pause_no_clk: assert property (o_switching |-> !o_sys_clk_en)
        else $error("clock enable during switch");
    a_pause_bounded: assert property ($rose(o_switching) |-> o_switching [*5] ##[0:300] !o_switching)
        else $error("switch pause length wrong");
    a_switch_lands: assert property ($fell(o_switching) && !o_clock_source_select[1]
        |-> o_active_source == o_clock_source_select) else $error("wrong source after switch");
    a_sec_flag_src: assert property (o_secondary_clock_running |-> $past(o_active_source) == 2'h1)
        else $error("secondary flag without secondary source");
    a_startup_src: assert property (o_primary_startup_done |-> $past(o_active_source) == 2'h0
        && !$past(o_switching)) else $error("startup flag without primary source");
    a_low_freq_slow: assert property (o_internal_freq_stable |-> !($past(o_internal_freq_select) == 3'h0
        && !$past(o_low_freq_source_select))) else $error("stable flag on slow source");
    a_sleep_entry: assert property (i_sleep && !i_wake && !o_idle_mode && !o_sleep_mode && !o_switching
        |=> o_idle_mode == $past(o_idle_on_sleep_select) && o_sleep_mode != $past(o_idle_on_sleep_select))
        else $error("wrong power mode on sleep");
    a_sec_keeps_run: assert property ((o_idle_mode || o_sleep_mode) && i_secondary_osc_enable
        |=> o_secondary_osc_run) else $error("secondary stopped when managed");
    c_to_secondary: cover property ($fell(o_switching) && o_active_source == 2'h1);
    c_idle: cover property (o_idle_mode);
    c_sleep: cover property (o_sleep_mode);
endmodule
bind css_clock_switch css_chk u_chk (.*);

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    logic       i_clk = 1'b0;
    logic       i_reset_n, i_primary_tick, i_secondary_tick, i_fast_internal_tick, i_slow_internal_tick;
    logic       i_pll_enable, i_ctrl_write, i_idle_on_sleep_select, i_tune_write, i_low_freq_source_select;
    logic       i_secondary_osc_enable, i_sleep, i_wake, o_sys_clk_en, o_wdt_clk_en, o_low_freq_source_select;
    logic       o_idle_on_sleep_select, o_primary_startup_done, o_internal_freq_stable, o_secondary_clock_running;
    logic       o_fast_internal_osc_on, o_secondary_osc_run, o_switching, o_idle_mode, o_sleep_mode;
    logic [3:0] i_primary_osc_config, o_primary_osc_config;
    logic [1:0] i_clock_source_select, o_active_source, o_clock_source_select;
    logic [2:0] i_internal_freq_select, o_internal_freq_select;
    logic [31:0] lfsr = 32'h1BD9;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int m_sel, m_freq, m_idle, m_lfss, l, c;
    int codes[$] = '{7, 6, 5, 4, 3, 2, 1, 0, 0};
    always #25 i_clk = ~i_clk;
    css_clock_switch #(.PLL_STARTUP_CYCLES(8)) DUT (.*);
    css_osc_model u_osc (.i_clk(i_clk), .i_sec_enable(i_secondary_osc_enable), .o_primary_tick(i_primary_tick),
        .o_secondary_tick(i_secondary_tick), .o_fast_tick(i_fast_internal_tick), .o_slow_tick(i_slow_internal_tick));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic end_sim();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic rst_chk();
        m_sel = 0;
        m_freq = 4;
        m_idle = 0;
        m_lfss = 0;
        chk("select", o_clock_source_select, 4'h0);
        chk("freq", o_internal_freq_select, 4'h4);
        chk("flags", {o_primary_startup_done, o_internal_freq_stable, o_secondary_clock_running}, 4'h0);
    endtask
    task automatic wr(input logic [1:0] s, input logic [2:0] f, input logic idl);
        @(posedge i_clk);
        i_ctrl_write <= 1'b1;
        i_clock_source_select <= s;
        i_internal_freq_select <= f;
        i_idle_on_sleep_select <= idl;
        @(posedge i_clk);
        i_ctrl_write <= 1'b0;
        #1;
        if (s != 2'h1 || i_secondary_osc_enable) m_sel = s;
        m_freq = f;
        m_idle = idl;
        chk("select", o_clock_source_select, 4'(m_sel));
        chk("freq", o_internal_freq_select, 4'(m_freq));
        chk("idle_sel", o_idle_on_sleep_select, 4'(m_idle));
    endtask
    task automatic wait_sw();
        int k;
        k = 0;
        while (o_switching !== 1'b1 && k < 8) begin step(1); k++; end
        k = 0;
        while (o_switching !== 1'b0 && k < 400) begin step(1); k++; end
        step(2);
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        while (o_primary_startup_done !== 1'b1 && k < 3000) begin step(1); k++; end
        chk("startup_done", o_primary_startup_done, 4'h1);
    endtask
    task automatic pulse(input logic slp);
        @(posedge i_clk);
        if (slp) i_sleep <= 1'b1; else i_wake <= 1'b1;
        @(posedge i_clk);
        i_sleep <= 1'b0;
        i_wake <= 1'b0;
        #1;
    endtask
    task automatic rate(input int exp);
        int n;
        n = 0;
        repeat (200) begin step(1); n += (o_sys_clk_en === 1'b1); end
        chk("rate_ok", 4'((n >= exp - 1) && (n <= exp + 1)), 4'h1);
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        // the run needs about 4500 cycles; a hang is stopped at the 20000-cycle budget
        if (cyc == 20000) begin n_mismatch++; end_sim(); end
    end
    initial begin
        {i_reset_n, i_ctrl_write, i_tune_write, i_sleep, i_wake, i_secondary_osc_enable} = '0;
        {i_clock_source_select, i_internal_freq_select, i_idle_on_sleep_select, i_low_freq_source_select} = '0;
        i_pll_enable = 1'b1;
        i_primary_osc_config = 4'(rnd());
        step(12);
        rst_chk();
        chk("fast_on", o_fast_internal_osc_on, 4'h1);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        step(2);
        chk("config", o_primary_osc_config, i_primary_osc_config);
        wait_done();
        wr(2'h1, 3'(rnd()), 1'b0);
        chk("select_refused", o_clock_source_select, 4'h0);
        @(posedge i_clk) i_secondary_osc_enable <= 1'b1;
        step(30); // let the secondary run before selecting it
        wr(2'h1, 3'h4, 1'b0);
        wait_sw();
        chk("active", o_active_source, 4'h1);
        chk("flags", {o_primary_startup_done, o_internal_freq_stable, o_secondary_clock_running}, 4'h1);
        for (int i = 0; i < codes.size(); i++) begin
            c = codes[i];
            l = (i == 7) ? 1 : (i == 8) ? 0 : int'(rnd() & 1);
            @(posedge i_clk);
            i_tune_write <= 1'b1;
            i_low_freq_source_select <= 1'(l);
            @(posedge i_clk);
            i_tune_write <= 1'b0;
            #1;
            m_lfss = l;
            chk("lfss", o_low_freq_source_select, 4'(m_lfss));
            wr(2'h2 + 2'(i & 1), 3'(c), 1'b0);
            wait_sw();
            step(40);
            chk("internal", o_active_source[1], 4'h1);
            chk("stable", o_internal_freq_stable, 4'(!(c == 0 && l == 0)));
            chk("fast_on", o_fast_internal_osc_on, 4'(!(c == 0 && l == 0)));
            rate((c == 0) ? (l ? 0 : 10) : (80 >> (7 - c)));
        end
        wr(2'h0, 3'h4, 1'b1);
        wait_sw();
        wait_done();
        for (int m = 1; m >= 0; m--) begin
            pulse(1'b1);
            chk("idle", o_idle_mode, 4'(m));
            chk("sleep", o_sleep_mode, 4'(1 - m));
            chk("sec_run", o_secondary_osc_run, 4'h1);
            pulse(1'b0);
            chk("modes", {o_idle_mode, o_sleep_mode}, 4'h0);
            wr(2'h0, 3'h4, 1'b0);
        end
        wr(2'h2, 3'h7, 1'b1);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        #1;
        rst_chk();
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        step(2);
        end_sim();
    end
endmodule
